// ==== rtl/asr_readout.sv ====
// Digital sequencer of the serial readout converter with power-down control.
// Operation
// RL1 - Unipolar range: straight binary 12-bit result.
// RL2 - Bipolar range: two's complement 12-bit result.
// RL3 - Power-up enters active state, ready to convert.
// RL4 - Two strobe rises without clock: light power-down.
// RL5 - Clock rise wakes light power-down; converts promptly.
// RL6 - Four strobe rises: deep power-down; clock wakes.
// RL7 - Settled flag low through reference recovery time.
// RL8 - Host avoids deep power-down more than every 2ms.
// RL9 - Strobe rise starts; further rises ignored 14 clocks.
// RL10 - Host chooses any strobe duty cycle.
// RL11 - Host makes strobe one clock period wide.
// RL12 - Each clock rise advances conversion and output bit.
// RL13 - Flag on second clock rise, then result MSB-first.
// RL14 - Frame carries 13 bits from second clock rise.
// RL15 - Output high impedance until first conversion starts.
// RL16 - Bit valid by next clock rise; host samples rises.
// RL17 - Host gives 16 clocks, discards trailing positions.
module asr_readout
  import asr_pkg::*;
#(
  parameter logic [SETTLE_W-1:0] SETTLE_LEN = SETTLE_W'(SETTLE_CYCLES)
) (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire logic                   sckPin,
  input  wire logic                   convertStrobePin,
  input  wire logic                   rangeBipolarPin,
  input  wire logic [RESULT_BITS-1:0] sampleCode,
  output logic                        dataOut,
  output logic                        dataOutEn_n,
  output logic                        napMode,
  output logic                        sleepMode,
  output logic                        refPowerOn,
  output logic                        referenceSettledFlag
);

  asr_state_t st;
  asr_state_t next_st;
  asr_pins_t  pinsIn;
  asr_pins_t  pinsLevel;
  asr_pins_t  pinsRise;
  logic       wakeFromSleep;
  logic       settleBusy;
  logic       convAccepted;
  logic [3:0] sckNext;
  logic [2:0] pdNext;

  // Host pins come from outside the clock domain and are synchronised first.
  assign pinsIn = '{sck: sckPin, convert_strobe: convertStrobePin, bipolar: rangeBipolarPin};

  asr_pin_sync u_sync (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .pinsIn    (pinsIn),
    .pinsLevel (pinsLevel),
    .pinsRise  (pinsRise)
  );

  // Reference recovery timer; held loaded while the reference is unpowered.
  asr_settle_timer #(
    .SETTLE_LEN (SETTLE_LEN)
  ) u_settle (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (wakeFromSleep),
    .hold    (st.mode == ASR_SLEEP),
    .busy    (settleBusy)
  );

  // The flag stays low while asleep and during the recovery count.
  assign referenceSettledFlag = (st.mode != ASR_SLEEP) && !settleBusy; // RL7

  // Next-state logic of the sequencer.
  always_comb begin
    next_st       = st;
    wakeFromSleep = 1'b0;
    convAccepted  = 1'b0;
    sckNext       = st.sckCount + 4'h1;
    pdNext        = st.pdCount;

    // A clock rise wakes the part and moves the frame on by one step.
    if (pinsRise.sck) begin
      pdNext       = '0;
      next_st.mode = ASR_ACTIVE; // RL5
      if (st.mode == ASR_SLEEP) begin
        wakeFromSleep = 1'b1; // RL6
      end
      if (st.frameOn) begin
        next_st.sckCount = sckNext; // RL12
        if ((sckNext >= FLAG_EDGE) && (sckNext <= LAST_BIT_EDGE)) begin
          next_st.dataOut = st.shift[FRAME_BITS-1]; // RL13
          next_st.driveOn = 1'b1; // RL14
          next_st.shift   = {st.shift[FRAME_BITS-2:0], 1'b0}; // RL12
        end else if (sckNext >= RELEASE_EDGE) begin
          next_st.driveOn = 1'b0;
          next_st.frameOn = 1'b0;
        end
      end
    end

    // Strobe rises with no clock rise between them count toward power-down.
    if (pinsRise.convert_strobe) begin
      if (pdNext != SLEEP_EDGES) begin
        pdNext = pdNext + 3'h1;
      end
      if (pdNext == SLEEP_EDGES) begin
        next_st.mode = ASR_SLEEP; // RL6
      end else if (pdNext >= NAP_EDGES) begin
        next_st.mode = ASR_NAP; // RL4
      end
      if (next_st.mode != ASR_ACTIVE) begin
        next_st.frameOn = 1'b0;
        next_st.driveOn = 1'b0;
      end
    end
    next_st.pdCount = pdNext;

    // A strobe rise starts a frame only when awake and outside the ignore window.
    convAccepted = pinsRise.convert_strobe && (next_st.mode == ASR_ACTIVE)
                   && !(st.frameOn && (st.sckCount < IGNORE_SCK)); // RL9

    // An accepted strobe samples the result and loads flag plus code; the line
    // stays released until the flag edge of the new frame.
    if (convAccepted) begin
      next_st.frameOn  = 1'b1; // RL9
      next_st.sckCount = '0;
      next_st.driveOn  = 1'b0; // RL13
      next_st.shift    = {referenceSettledFlag,
                          asr_format(sampleCode, pinsLevel.bipolar)}; // RL1 RL2
    end
  end

  // Registers the sequencer; reset gives the active state, output released.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st      <= '0; // RL3 RL15
      st.mode <= ASR_ACTIVE; // RL3
    end else begin
      st <= next_st;
    end
  end

  // Pin drivers and power indications come straight from registers.
  assign dataOut     = st.dataOut; // RL16
  assign dataOutEn_n = ~st.driveOn; // RL15
  assign napMode     = (st.mode == ASR_NAP);
  assign sleepMode   = (st.mode == ASR_SLEEP);
  assign refPowerOn  = (st.mode != ASR_SLEEP); // RL4

  // Checks of the sequencer behaviour.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // A frame start: accepted strobe, then an open frame with a cleared clock count.
  sequence s_frame_start;
    convAccepted ##1 st.frameOn && (st.sckCount == 4'h0);
  endsequence

  sequence s_flag_edge;
    pinsRise.sck && st.frameOn && (st.sckCount == 4'h1);
  endsequence

  // A strobe that is taken opens a frame with a cleared clock count.
  a_frame_begin: assert property (convAccepted |=> st.frameOn && (st.sckCount == 4'h0)) // RL9
    else $error("Accepted strobe did not open a frame.");

  // A strobe rise inside the ignore window leaves the running frame alone.
  a_convert_strobe_ignored: assert property ( // RL9
    st.frameOn && (st.sckCount < IGNORE_SCK) && pinsRise.convert_strobe && !pinsRise.sck
    && (st.pdCount == 3'h0) |=> (st.sckCount == $past(st.sckCount)))
    else $error("Strobe rise restarted a frame inside the ignore window.");

  // A new frame has the line released in the cycle after its strobe is taken.
  a_flag_drive: assert property ( // RL15
    s_frame_start ##0 1'b1 |-> dataOutEn_n)
    else $error("Output driven before the flag edge.");

  // The second clock rise of a frame drives the settled flag.
  a_flag_bit: assert property ( // RL13
    s_flag_edge and !pinsRise.convert_strobe
    |=> !dataOutEn_n && (dataOut == $past(st.shift[FRAME_BITS-1])))
    else $error("Flag bit not presented on the second clock rise.");

  // Clock rises two to fourteen of a frame move the result shift on by one bit.
  a_bit_advance: assert property ( // RL12
    pinsRise.sck && !pinsRise.convert_strobe && st.frameOn && (st.sckCount >= 4'h1)
    && (st.sckCount < 4'hE)
    |=> (st.shift[FRAME_BITS-1:1] == $past(st.shift[FRAME_BITS-2:0])))
    else $error("Clock rise did not advance the result shift.");

  // The clock rise after the last result bit releases the line.
  a_frame_release: assert property ( // RL14
    pinsRise.sck && !pinsRise.convert_strobe && st.frameOn && (st.sckCount == 4'hE)
    |=> dataOutEn_n && !st.frameOn)
    else $error("Output not released after the thirteenth bit.");

  // The line is only ever enabled by the flag edge of a frame.
  a_drive_cause: assert property ( // RL15
    $fell(dataOutEn_n) |-> $past(pinsRise.sck) && ($past(st.sckCount) == 4'h1))
    else $error("Output enabled without a frame flag edge.");

  // A second strobe rise with no clock rise enters light power-down.
  a_nap_entry: assert property ( // RL4
    (st.mode == ASR_ACTIVE) && (st.pdCount == 3'h1) && pinsRise.convert_strobe && !pinsRise.sck
    |=> napMode)
    else $error("Two strobe rises did not enter light power-down.");

  // A fourth strobe rise with no clock rise enters deep power-down.
  a_sleep_entry: assert property ( // RL6
    (st.pdCount == 3'h3) && pinsRise.convert_strobe && !pinsRise.sck |=> sleepMode && !refPowerOn)
    else $error("Four strobe rises did not enter deep power-down.");

  // Any clock rise wakes the converter from either power-down.
  a_clock_wake: assert property ( // RL5
    (napMode || sleepMode) && pinsRise.sck |=> !napMode && !sleepMode)
    else $error("Clock rise did not wake the converter.");

  // The settled flag stays low for a while after a deep power-down wake.
  a_flag_recover: assert property ( // RL7
    sleepMode && pinsRise.sck |=> !referenceSettledFlag [*8])
    else $error("Settled flag rose too soon after deep power-down.");

  // The sign bit follows the selected range.
  a_code_format: assert property ( // RL1 RL2
    convAccepted |=> (st.shift[RESULT_BITS-1] ==
      ($past(sampleCode[RESULT_BITS-1]) ^ $past(pinsLevel.bipolar))))
    else $error("Result sign bit not formatted for the selected range.");

  // Outside a frame the output stays released.
  a_idle_release: assert property ( // RL15
    !st.frameOn |-> dataOutEn_n)
    else $error("Output driven with no frame open.");

  // No strobe is taken before the ignore window has passed.
  a_no_restart: assert property ( // RL9
    st.frameOn && (st.sckCount < IGNORE_SCK) |-> !convAccepted)
    else $error("Strobe taken inside the ignore window.");

  // An awake converter with no frame open takes the first strobe rise at once.
  a_wake_accept: assert property ( // RL5
    (st.mode == ASR_ACTIVE) && !st.frameOn && (st.pdCount == 3'h0) && pinsRise.convert_strobe
    |-> convAccepted)
    else $error("Awake converter refused a strobe.");

  // A driven bit stands until the next clock or strobe rise.
  a_drive_hold: assert property ( // RL16
    !dataOutEn_n && !pinsRise.sck && !pinsRise.convert_strobe |=> !dataOutEn_n && $stable(dataOut))
    else $error("Driven bit changed between clock rises.");

  // The output bit only moves on a clock rise.
  a_bit_edge_only: assert property ( // RL12
    $changed(dataOut) |-> $past(pinsRise.sck))
    else $error("Output bit moved with no clock rise seen.");

  // A released line stays released until a clock rise.
  a_release_hold: assert property ( // RL15
    dataOutEn_n && !pinsRise.sck |=> dataOutEn_n)
    else $error("Output enabled without a clock rise.");

  // A clock rise clears the count of strobe rises.
  a_pd_clear: assert property ( // RL4 RL6
    pinsRise.sck && !pinsRise.convert_strobe |=> (st.pdCount == 3'h0))
    else $error("Clock rise did not clear the power-down count.");

  // The strobe rise count saturates at the deep power-down level.
  a_pd_limit: assert property ( // RL6
    st.pdCount <= SLEEP_EDGES)
    else $error("Power-down count ran past its limit.");

  // Light power-down lasts until a clock rise or an entry into deep power-down.
  a_nap_hold: assert property ( // RL4
    napMode && !pinsRise.sck |=> napMode || sleepMode)
    else $error("Light power-down left without a clock rise.");

  // Deep power-down lasts until a clock rise.
  a_sleep_hold: assert property ( // RL6
    sleepMode && !pinsRise.sck |=> sleepMode)
    else $error("Deep power-down left without a clock rise.");

  // Light power-down keeps the reference on and the line released.
  a_nap_quiet: assert property ( // RL4
    napMode |-> dataOutEn_n && refPowerOn)
    else $error("Light power-down drove the line or cut the reference.");

  // Deep power-down turns the reference off and clears the settled flag.
  a_sleep_quiet: assert property ( // RL6 RL7
    sleepMode |-> dataOutEn_n && !refPowerOn && !referenceSettledFlag)
    else $error("Deep power-down left the reference or the line active.");

  // A wake from deep power-down starts the recovery count.
  a_settle_start: assert property ( // RL7
    sleepMode && pinsRise.sck |=> settleBusy)
    else $error("Wake from deep power-down did not start the recovery count.");

  // The settled flag stays low while the recovery count runs.
  a_settle_flag: assert property ( // RL7
    settleBusy |-> !referenceSettledFlag)
    else $error("Settled flag high during the recovery count.");

  // An open frame never counts past the release edge.
  a_frame_bound: assert property ( // RL14
    st.frameOn |-> (st.sckCount < RELEASE_EDGE))
    else $error("Frame clock count ran past the release edge.");

endmodule

// ==== rtl/asr_pkg.sv ====
// Shared constants, types and helpers of the serial readout converter logic.
package asr_pkg;

  // Result and frame geometry.
  localparam int          RESULT_BITS   = 12;
  localparam int          FRAME_BITS    = RESULT_BITS + 1;
  localparam logic [3:0]  FLAG_EDGE     = 4'h2;
  localparam logic [3:0]  LAST_BIT_EDGE = 4'hE;
  localparam logic [3:0]  IGNORE_SCK    = 4'hE;
  localparam logic [3:0]  RELEASE_EDGE  = 4'hF;

  // Strobe edge counts that select the power-down depth.
  localparam logic [2:0]  NAP_EDGES     = 3'h2;
  localparam logic [2:0]  SLEEP_EDGES   = 3'h4;

  // Reference recovery after deep power-down: slew time plus extra settle time.
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          REF_SLEW_US   = 2000;
  localparam int          REF_EXTRA_US  = 10000;
  localparam int          SETTLE_CYCLES =
    ((REF_SLEW_US + REF_EXTRA_US) * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_W      = 21;

  // Power states of the converter.
  typedef enum logic [1:0] {
    ASR_ACTIVE,
    ASR_NAP,
    ASR_SLEEP
  } asr_mode_t;

  // Host-facing pins that are sampled together.
  typedef struct packed {
    logic sck;
    logic convert_strobe;
    logic bipolar;
  } asr_pins_t;

  // Whole state of the readout sequencer.
  typedef struct packed {
    asr_mode_t                mode;
    logic [2:0]               pdCount;
    logic                     frameOn;
    logic [3:0]               sckCount;
    logic [FRAME_BITS-1:0]    shift;
    logic                     dataOut;
    logic                     driveOn;
  } asr_state_t;

  // Formats a raw offset-binary code as straight binary or two's complement.
  function automatic logic [RESULT_BITS-1:0] asr_format(
    input logic [RESULT_BITS-1:0] code,
    input logic                   bipolar
  );
    asr_format = code;
    if (bipolar) begin
      asr_format[RESULT_BITS-1] = ~code[RESULT_BITS-1];
    end
  endfunction

endpackage

// ==== rtl/asr_pin_sync.sv ====
// Two-stage synchroniser and rising edge finder for the host pins.
module asr_pin_sync
  import asr_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      nrst,
  input  wire asr_pins_t pinsIn,
  output asr_pins_t      pinsLevel,
  output asr_pins_t      pinsRise
);

  typedef struct packed {
    asr_pins_t meta;
    asr_pins_t stable;
    asr_pins_t last;
  } asr_sync_t;

  asr_sync_t st;
  asr_sync_t next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st        = st;
    next_st.meta   = pinsIn;
    next_st.stable = st.meta;
    next_st.last   = st.stable;
  end

  // Registers the synchroniser chain.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Level and one-cycle rise pulses from the settled stages.
  assign pinsLevel = st.stable;
  assign pinsRise  = st.stable & ~st.last;

endmodule

// ==== rtl/asr_settle_timer.sv ====
// Counts the reference recovery time after a wake from deep power-down.
module asr_settle_timer
  import asr_pkg::*;
#(
  parameter logic [SETTLE_W-1:0] SETTLE_LEN = SETTLE_W'(SETTLE_CYCLES)
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic hold,
  output logic      busy
);

  typedef struct packed {
    logic                busy;
    logic [SETTLE_W-1:0] left;
  } asr_timer_t;

  asr_timer_t st;
  asr_timer_t next_st;

  // Start reloads, hold keeps the count stopped while the reference is off.
  always_comb begin
    next_st = st;
    if (start || hold) begin
      next_st.busy = 1'b1;
      next_st.left = SETTLE_LEN;
    end else if (st.busy) begin
      if (st.left <= SETTLE_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.left = '0;
      end else begin
        next_st.left = st.left - SETTLE_W'(1);
      end
    end
  end

  // Registers the timer state.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;

endmodule

// ==== testbench/asr_host_model.sv ====
// Host model that drives the shift clock and conversion strobe and samples serial data.
module asr_host_model (
  output logic      sckPin,
  output logic      convertStrobePin,
  input  wire logic dataOut,
  input  wire logic dataOutEn_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released data line has no pull, so it shows the inverse of the last bit driven.
  wire sdoWire = dataOutEn_n ? ~dataOut : dataOut;

  // Both host pins rest low, and the shift clock stands still outside frames and wake pulses.
  initial begin
    sckPin = 1'b0;
    convertStrobePin = 1'b0;
  end

  // Strobe pulses with no shift clock in between, which selects a power-down depth.
  task automatic strobes(input int n);
    repeat (n) begin
      convertStrobePin <= 1'b1;
      #125;
      convertStrobePin <= 1'b0;
      #125;
    end
  endtask

  // One shift clock pulse, which wakes the part from either power-down.
  task automatic wake();
    sckPin <= 1'b1;
    #62;
    sckPin <= 1'b0;
    #63;
  endtask

  // One frame of 16 clocks; an optional extra strobe pulse lands after rise glitchAt.
  task automatic frame(input int glitchAt, output logic [12:0] bits, output logic [15:0] enSeen);
    bits = 13'h0000;
    convertStrobePin <= 1'b1;
    #62;
    for (int r = 1; r <= 16; r++) begin
      enSeen[r-1] = dataOutEn_n;
      if (r >= 3 && r <= 15) bits[15-r] = sdoWire;
      sckPin = 1'b1;
      #62;
      if (r == 1) convertStrobePin = 1'b0;
      if (r == glitchAt) convertStrobePin = 1'b1;
      if (r == glitchAt + 1) convertStrobePin = 1'b0;
      sckPin = 1'b0;
      #63;
    end
  endtask
endmodule

// ==== testbench/asr_readout_bench.sv ====
// Self-checking testbench of the serial readout converter sequencer.
module asr_readout_bench
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        bip;
    logic [11:0] code;
    logic [11:0] want;
  } asr_row_t;

  localparam asr_row_t ROWS [7] = '{
    '{1'b0, 12'h000, 12'h000}, '{1'b0, 12'hFFF, 12'hFFF}, '{1'b0, 12'h5A3, 12'h5A3},
    '{1'b1, 12'h800, 12'h000}, '{1'b1, 12'h000, 12'h800}, '{1'b1, 12'hFFF, 12'h7FF},
    '{1'b1, 12'h7FF, 12'hFFF}};

  logic        ref_clk = 1'b0;
  logic        nrst;
  logic        sckPin;
  logic        convertStrobePin;
  logic        rangeBipolarPin;
  logic [11:0] sampleCode;
  logic        dataOut;
  logic        dataOutEn_n;
  logic        napMode;
  logic        sleepMode;
  logic        refPowerOn;
  logic        referenceSettledFlag;
  int          num_errors = 0;
  int          num_checks = 0;

  // The system clock toggles every half period of 10 ns.
  always #5 ref_clk = ~ref_clk;

  asr_readout #(.SETTLE_LEN(21'h000C8)) asr_readout_inst (
    .ref_clk              (ref_clk),
    .nrst                 (nrst),
    .sckPin               (sckPin),
    .convertStrobePin     (convertStrobePin),
    .rangeBipolarPin      (rangeBipolarPin),
    .sampleCode           (sampleCode),
    .dataOut              (dataOut),
    .dataOutEn_n          (dataOutEn_n),
    .napMode              (napMode),
    .sleepMode            (sleepMode),
    .refPowerOn           (refPowerOn),
    .referenceSettledFlag (referenceSettledFlag)
  );

  asr_host_model asr_host_model_inst (
    .sckPin           (sckPin),
    .convertStrobePin (convertStrobePin),
    .dataOut          (dataOut),
    .dataOutEn_n      (dataOutEn_n)
  );

  // Compares one value and counts the outcome.
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits a bounded time for {nap, sleep, refOn, flag} to reach a state, then compares.
  task automatic check_mode(input logic [3:0] exp, input int bound);
    logic [3:0] got;
    got = {napMode, sleepMode, refPowerOn, referenceSettledFlag};
    for (int i = 0; i < bound && got !== exp; i++) begin
      @(posedge ref_clk);
      got = {napMode, sleepMode, refPowerOn, referenceSettledFlag};
    end
    check_word("power state", 16'(exp), 16'(got));
  endtask

  // Sets the range and core code, runs one frame and checks bits and drive window.
  task automatic run_frame(input logic bip, input logic [11:0] code, input logic [12:0] want,
                           input int glitchAt);
    logic [12:0] bits;
    logic [15:0] enSeen;
    @(posedge ref_clk);
    rangeBipolarPin <= bip;
    sampleCode <= code;
    @(posedge ref_clk);
    asr_host_model_inst.frame(glitchAt, bits, enSeen);
    check_word("frame bits", 16'(want), 16'(bits));
    check_word("drive window", 16'h8003, enSeen);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reset, the table of ordinary frames, then a frame with an ignored strobe and power-down.
  initial begin
    nrst = 1'b0;
    rangeBipolarPin = 1'b0;
    sampleCode = 12'h000;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    check_mode(4'h3, 1);
    check_word("idle enable", 16'h0001, 16'(dataOutEn_n));
    for (int i = 0; i < 7; i++) begin
      run_frame(ROWS[i].bip, ROWS[i].code, {1'b1, ROWS[i].want}, 0);
    end
    run_frame(1'b0, 12'h3C5, 13'h13C5, 8);
    asr_host_model_inst.strobes(2);
    check_mode(4'hB, 60);
    asr_host_model_inst.wake();
    check_mode(4'h3, 60);
    run_frame(1'b1, 12'h9A6, 13'h11A6, 0);
    asr_host_model_inst.strobes(4);
    check_mode(4'h4, 60);
    asr_host_model_inst.wake();
    check_mode(4'h2, 60);
    run_frame(1'b0, 12'hABC, 13'h0ABC, 0);
    check_mode(4'h3, 400);
    run_frame(1'b0, 12'hABC, 13'h1ABC, 0);
    give_verdict();
  end
endmodule
